/* File: rtl/dcic_pkg.sv */
// Package with register map, cause bit positions and constants for the datacomm interrupt block.
package dcic_pkg;

    // Register byte addresses on the AHB-Lite slave.
    localparam logic [7:0] ADDR_CAUSE = 8'h04;
    localparam logic [7:0] ADDR_MASK = 8'h00;
    localparam logic [7:0] ADDR_RXQ = 8'h08;
    localparam logic [7:0] ADDR_CTRL = 8'h0C;
    localparam logic [7:0] ADDR_RXDATA = 8'h10;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h14;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;

    // Cause bit positions shared by both protocols.
    localparam int CB_RXDATA = 0;
    localparam int CB_PROMPT_OR_SENT = 1;
    localparam int CB_ERROR = 2;
    localparam int CB_MODEM = 3;
    localparam int CB_NOACT = 4;
    localparam int CB_LOSTCAR = 5;
    // Cause bit positions used in asynchronous mode only.
    localparam int CB_EOL = 6;
    localparam int CB_BREAK = 7;

    // Control register field positions.
    localparam int CTRL_DATALINK = 0;
    localparam int CTRL_HANDSHAKE = 1;

    // Receive queue status codes.
    localparam logic [1:0] RXQ_EMPTY = 2'h0;
    localparam logic [1:0] RXQ_DATA = 2'h1;
    localparam logic [1:0] RXQ_CTRL = 2'h2;
    localparam logic [1:0] RXQ_BOTH = 2'h3;

    // Reset values.
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [1:0] CTRL_RESET = 2'h0;

    // Cause bits that hold meaning in Data Link mode.
    localparam logic [7:0] DATALINK_VALID = 8'h3F;

    // Block interrupt sources: overflow and queue-empty-after-read.
    localparam int IRQ_OVERFLOW = 0;
    localparam int IRQ_DRAINED = 1;

    // AHB transfer type and size codes.
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

endpackage : dcic_pkg

/* File: rtl/dcic_rxq.sv */
// Receive queue holding data bytes and control block markers in flip-flops.
`timescale 1ns/1ps
module dcic_rxq
    import dcic_pkg::*;
#(
    parameter int DEPTH = 16
) (
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // Incoming entries from the line side.
    input wire logic wr_en,
    input wire logic [7:0] wr_data,
    input wire logic wr_ctrl,
    // Reads from the host side.
    input wire logic rd_en,
    output logic [7:0] rd_data,
    output logic rd_ctrl,
    // Occupancy view.
    output logic empty,
    output logic full,
    output logic has_data,
    output logic has_ctrl,
    output logic overflow
);

    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
            $error("dcic_rxq: DEPTH must be a power of two of at least 2.");
        end
    end

    localparam int AW = $clog2(DEPTH);

    // Storage, one entry holds a byte and a control marker.
    logic [8:0] mem [DEPTH];
    logic [AW:0] wptr;
    logic [AW:0] rptr;
    logic [AW:0] ctrl_count;
    logic [AW:0] next_wptr;
    logic [AW:0] next_rptr;
    logic [AW:0] next_ctrl_count;
    logic do_wr;
    logic do_rd;

    // Counts and pointers for the next cycle; a write to a full queue is dropped.
    always_comb begin
        do_wr = wr_en && !full;
        do_rd = rd_en && !empty;
        next_wptr = wptr + (AW + 1)'(do_wr);
        next_rptr = rptr + (AW + 1)'(do_rd);
        next_ctrl_count = ctrl_count + (AW + 1)'(do_wr && wr_ctrl)
                          - (AW + 1)'(do_rd && mem[rptr[AW-1:0]][8]);
        overflow = wr_en && full;
    end

    // Pointer registers.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wptr <= '0;
            rptr <= '0;
            ctrl_count <= '0;
        end else begin
            wptr <= next_wptr;
            rptr <= next_rptr;
            ctrl_count <= next_ctrl_count;
        end
    end

    // Storage has no reset; rd_data shows the entry at rptr even when the queue is empty.
    always_ff @(posedge hclk) begin
        if (do_wr) begin
            mem[wptr[AW-1:0]] <= {wr_ctrl, wr_data};
        end
    end

    assign empty = (wptr == rptr);
    assign full = (wptr[AW-1:0] == rptr[AW-1:0]) && (wptr[AW] != rptr[AW]);
    assign has_ctrl = (ctrl_count != '0);
    assign has_data = ((wptr - rptr) != ctrl_count);
    assign rd_data = mem[rptr[AW-1:0]][7:0];
    assign rd_ctrl = mem[rptr[AW-1:0]][8];

endmodule : dcic_rxq

/* File: rtl/dcic_top.sv */
// Datacomm interrupt cause, enable mask and receive queue with AHB-Lite registers.
//
// Contract
// - Cause register records causes of latest request.
// - Event interrupts only when its mask bit set.
// - Bits 0-5 shared; 6-7 async only.
// - Async bits 0-3: data, prompt, error, modem.
// - Async bits 4-7: noact, lostcarrier, EOL, break.
// - Data Link bit1 block sent, bit2 error.
// - Queue holds data; full with handshake holds off.
// - Async without handshake: no hold-off, overflow.
// - Cause read clears request; uncleared stays asserted.
// - Queue status: 0 empty,1 data,2 ctrl,3 both.
`timescale 1ns/1ps
module dcic_top
    import dcic_pkg::*;
#(
    parameter int RXQ_DEPTH = 16
) (
    // AHB-Lite clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave port.
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Line events, one-cycle pulses from the protocol engine.
    input wire logic ev_prompt_or_sent,
    input wire logic ev_error,
    input wire logic ev_modem,
    input wire logic ev_noact,
    input wire logic ev_lostcar,
    input wire logic ev_eol,
    input wire logic ev_break,
    // Received entries from the protocol engine.
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_ctrl,
    // Host request and remote hold-off.
    output logic host_irq,
    output logic hold_off,
    // Block interrupt for queue overflow and drain.
    output logic irq
);

    // Bus address phase captured for the data phase.
    logic ap_valid;
    logic ap_write;
    logic [7:0] ap_addr;
    logic next_ap_valid;
    logic next_ap_write;
    logic [7:0] next_ap_addr;

    // Software-visible state.
    logic [7:0] mask;          // Host enable mask.
    logic [7:0] cause;         // Latched causes.
    logic [1:0] ctrl;          // Protocol mode and handshake enable.
    logic [1:0] irq_status;    // Sticky block events.
    logic [1:0] irq_mask;      // Enables for the block events.
    logic [7:0] next_mask;
    logic [7:0] next_cause;
    logic [1:0] next_ctrl;
    logic [1:0] next_irq_status;
    logic [1:0] next_irq_mask;
    logic [31:0] next_hrdata;
    logic next_host_irq;
    logic next_hold_off;
    logic next_irq;

    // Queue wiring.
    logic q_rd;
    logic [7:0] q_data;
    logic q_rd_ctrl;
    logic q_empty;
    logic q_full;
    logic q_has_data;
    logic q_has_ctrl;
    logic q_overflow;
    logic q_empty_d;
    logic next_q_empty_d;

    // Decoded accesses; writes to the cause register are ignored.
    logic rd_cause;
    logic [7:0] events;
    logic [7:0] valid_bits;

    // Receive queue; writes while full are dropped and flagged.
    dcic_rxq #(
        .DEPTH(RXQ_DEPTH)
    ) u_rxq (
        .hclk(hclk),
        .hresetn(hresetn),
        .wr_en(rx_valid),
        .wr_data(rx_data),
        .wr_ctrl(rx_ctrl),
        .rd_en(q_rd),
        .rd_data(q_data),
        .rd_ctrl(q_rd_ctrl),
        .empty(q_empty),
        .full(q_full),
        .has_data(q_has_data),
        .has_ctrl(q_has_ctrl),
        .overflow(q_overflow)
    );

    // Queue status code from occupancy.
    function automatic logic [1:0] rxq_code(input logic d, input logic c);
        if (d && c) begin
            return RXQ_BOTH;
        end else if (c) begin
            return RXQ_CTRL;
        end else if (d) begin
            return RXQ_DATA;
        end
        return RXQ_EMPTY;
    endfunction : rxq_code

    // Address phase capture; the slave never inserts wait states.
    always_comb begin
        next_ap_valid = hsel && hready && (htrans == HTRANS_NONSEQ) && (hsize == HSIZE_WORD);
        next_ap_write = hwrite;
        next_ap_addr = haddr;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_valid <= 1'b0;
            ap_write <= 1'b0;
            ap_addr <= 8'h00;
        end else begin
            ap_valid <= next_ap_valid;
            ap_write <= next_ap_write;
            ap_addr <= next_ap_addr;
        end
    end

    // Read strobes act on the edge that loads hrdata. Clearing the cause on that
    // same edge means an event latched then is kept, not wiped unreported.
    assign rd_cause = next_ap_valid && !hwrite && (haddr == ADDR_CAUSE);
    assign q_rd = next_ap_valid && !hwrite && (haddr == ADDR_RXDATA);

    // Event vector; bit 1 is prompt or block sent by mode, and bits 6-7 count in async mode only.
    always_comb begin
        events = 8'h00;
        events[CB_RXDATA] = !q_empty;
        events[CB_PROMPT_OR_SENT] = ev_prompt_or_sent;
        events[CB_ERROR] = ev_error;
        events[CB_MODEM] = ev_modem;
        events[CB_NOACT] = ev_noact;
        events[CB_LOSTCAR] = ev_lostcar;
        events[CB_EOL] = ev_eol;
        events[CB_BREAK] = ev_break;
        // Data Link has no use for the upper pair, so they never latch.
        valid_bits = ctrl[CTRL_DATALINK] ? DATALINK_VALID : 8'hFF;
    end

    // Register next values. An event arriving in the clearing read is kept.
    always_comb begin
        next_mask = mask;
        next_ctrl = ctrl;
        next_irq_mask = irq_mask;
        next_cause = cause;
        next_irq_status = irq_status;
        next_q_empty_d = q_empty;
        if (rd_cause) begin
            next_cause = 8'h00;
        end
        // Only masked events latch, so the cause shows what raised the request.
        next_cause = next_cause | (events & mask & valid_bits);
        if (q_overflow) begin
            next_irq_status[IRQ_OVERFLOW] = 1'b1;
        end
        if (q_empty && !q_empty_d) begin
            next_irq_status[IRQ_DRAINED] = 1'b1;
        end
        if (ap_valid && ap_write) begin
            if (ap_addr == ADDR_MASK) begin
                next_mask = hwdata[7:0];
            end else if (ap_addr == ADDR_CTRL) begin
                next_ctrl = hwdata[1:0];
            end else if (ap_addr == ADDR_IRQ_STATUS) begin
                next_irq_status = next_irq_status & ~(hwdata[1:0] & irq_status);
                if (q_overflow) begin
                    next_irq_status[IRQ_OVERFLOW] = 1'b1;
                end
                if (q_empty && !q_empty_d) begin
                    next_irq_status[IRQ_DRAINED] = 1'b1;
                end
            end else if (ap_addr == ADDR_IRQ_MASK) begin
                next_irq_mask = hwdata[1:0];
            end
        end
        // A later event while pending only adds bits; one level request.
        next_host_irq = ((next_cause & mask) != 8'h00);
        next_hold_off = ctrl[CTRL_HANDSHAKE] && q_full;
        next_irq = ((next_irq_status & next_irq_mask) != 2'h0);
    end

    // Read data for the next data phase, computed from the address phase.
    always_comb begin
        next_hrdata = 32'h00000000;
        if (next_ap_valid && !hwrite) begin
            if (haddr == ADDR_MASK) begin
                next_hrdata = {24'h000000, mask};
            end else if (haddr == ADDR_CAUSE) begin
                next_hrdata = {24'h000000, cause};
            end else if (haddr == ADDR_RXQ) begin
                next_hrdata = {30'h00000000, rxq_code(q_has_data, q_has_ctrl)};
            end else if (haddr == ADDR_CTRL) begin
                next_hrdata = {30'h00000000, ctrl};
            end else if (haddr == ADDR_RXDATA) begin
                next_hrdata = {23'h000000, q_rd_ctrl && !q_empty, q_data};
            end else if (haddr == ADDR_IRQ_STATUS) begin
                next_hrdata = {30'h00000000, irq_status};
            end else if (haddr == ADDR_IRQ_MASK) begin
                next_hrdata = {30'h00000000, irq_mask};
            end
        end
    end

    // State registers; hrdata, host_irq, hold_off and irq leave from flip-flops.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mask <= MASK_RESET;
            cause <= 8'h00;
            ctrl <= CTRL_RESET;
            irq_status <= 2'h0;
            irq_mask <= 2'h0;
            q_empty_d <= 1'b1;
            hrdata <= 32'h00000000;
            host_irq <= 1'b0;
            hold_off <= 1'b0;
            irq <= 1'b0;
        end else begin
            mask <= next_mask;
            cause <= next_cause;
            ctrl <= next_ctrl;
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
            q_empty_d <= next_q_empty_d;
            hrdata <= next_hrdata;
            host_irq <= next_host_irq;
            hold_off <= next_hold_off;
            irq <= next_irq;
        end
    end

    // Zero wait states and OKAY always; bus response outputs tied to constants.
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Checks.
    property p_masked_latch;
        @(posedge hclk) disable iff (!hresetn)
        (ev_modem && !mask[CB_MODEM] && !cause[CB_MODEM]) |=> !cause[CB_MODEM];
    endproperty
    a_masked_latch: assert property (p_masked_latch) else $error("Masked cause latched.");

    property p_cause_latch;
        @(posedge hclk) disable iff (!hresetn)
        (ev_noact && mask[CB_NOACT]) |=> cause[CB_NOACT];
    endproperty
    a_cause_latch: assert property (p_cause_latch) else $error("Cause not latched.");

    property p_dl_upper;
        @(posedge hclk) disable iff (!hresetn)
        (ctrl[CTRL_DATALINK] && $past(ctrl[CTRL_DATALINK]) && rd_cause) |=>
            (cause[CB_BREAK] == 1'b0);
    endproperty
    a_dl_upper: assert property (p_dl_upper) else $error("Upper bit set in Data Link.");

    property p_read_clears;
        @(posedge hclk) disable iff (!hresetn)
        (rd_cause && !ev_break) |=> !cause[CB_BREAK];
    endproperty
    a_read_clears: assert property (p_read_clears) else $error("Cause read did not clear.");

    property p_irq_level;
        @(posedge hclk) disable iff (!hresetn)
        ((cause & mask) != 8'h00) && !rd_cause && $stable(mask) |=> host_irq;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("Request not held.");

    property p_holdoff;
        @(posedge hclk) disable iff (!hresetn)
        (q_full && ctrl[CTRL_HANDSHAKE]) |=> hold_off;
    endproperty
    a_holdoff: assert property (p_holdoff) else $error("No hold-off when full.");

    property p_no_holdoff;
        @(posedge hclk) disable iff (!hresetn)
        !ctrl[CTRL_HANDSHAKE] |=> !hold_off;
    endproperty
    a_no_holdoff: assert property (p_no_holdoff) else $error("Hold-off without handshake.");

    property p_rxq_code;
        @(posedge hclk) disable iff (!hresetn)
        (next_ap_valid && !hwrite && haddr == ADDR_RXQ && q_empty) |=> hrdata[1:0] == RXQ_EMPTY;
    endproperty
    a_rxq_code: assert property (p_rxq_code) else $error("Queue status wrong.");

endmodule : dcic_top

/* File: bench/dcic_remote.sv */
// Remote sender model that feeds entries into the receive queue.
`timescale 1ns/1ps
module dcic_remote (
    // Clock, reset and hold-off from the block.
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hold_off,
    // Entries toward the block.
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_ctrl
);
    // The line starts idle.
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
        rx_ctrl = 1'b0;
    end

    // Sends one entry; a polite sender waits two cycles, then waits for hold-off low before it sends.
    // Idle lines carry the inverse of the last entry, so stale data never matches.
    task automatic send(input logic [7:0] d, input logic c, input logic honour);
        repeat (2) @(posedge hclk);
        #1;
        while (honour && hold_off !== 1'b0) begin
            @(posedge hclk);
            #1;
        end
        @(posedge hclk);
        rx_valid <= 1'b1;
        rx_data <= d;
        rx_ctrl <= c;
        @(posedge hclk);
        rx_valid <= 1'b0;
        rx_data <= ~d;
        rx_ctrl <= ~c;
    endtask : send
endmodule : dcic_remote

/* File: bench/testbench.sv */
// Self-checking testbench for the datacomm interrupt cause and queue block.
`timescale 1ns/1ps
module testbench;
    import dcic_pkg::*;
    localparam int DEPTH = 4; // Small queue keeps fills short.
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h0;
    logic [31:0] hwdata = 32'h0;
    logic hready;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [7:0] ev = 8'h00; // Event pulses, bits 1-7 drive cause bits 1-7.
    logic rx_valid;
    logic [7:0] rx_data;
    logic rx_ctrl;
    logic host_irq;
    logic hold_off;
    logic irq;
    int miscompares = 0;
    int checks_done = 0;
    integer seed = 87496;
    logic [31:0] rd; // Last read data.
    logic [7:0] mask;
    logic [7:0] exp_cause;
    logic [8:0] q[$]; // Model of the receive queue.

    always #50 hclk = ~hclk;
    // The one slave drives the bus ready.
    assign hready = hreadyout;

    dcic_top #(.RXQ_DEPTH(DEPTH)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .ev_prompt_or_sent(ev[1]), .ev_error(ev[2]), .ev_modem(ev[3]), .ev_noact(ev[4]),
        .ev_lostcar(ev[5]), .ev_eol(ev[6]), .ev_break(ev[7]), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_ctrl(rx_ctrl), .host_irq(host_irq), .hold_off(hold_off),
        .irq(irq));

    dcic_remote u_remote (.hclk(hclk), .hresetn(hresetn), .hold_off(hold_off),
        .rx_valid(rx_valid), .rx_data(rx_data), .rx_ctrl(rx_ctrl));

    // Compares a register word.
    task automatic cmp_word(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %0h seen %0h", n, e, g);
        end
    endtask : cmp_word

    // Compares a single output flag.
    task automatic cmp_flag(input string n, input logic e, input logic g);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %b seen %b", n, e, g);
        end
    endtask : cmp_flag

    // One single-word transfer; waits for ready in both phases.
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        hsize <= HSIZE_WORD;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : bus

    // Reads a register and compares it.
    task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        cmp_word(n, e, rd);
    endtask : rd_chk

    // Pulses one event for a cycle, then waits until the request is due.
    task automatic pulse(input int b);
        @(posedge hclk);
        ev[b] <= 1'b1;
        @(posedge hclk);
        ev <= 8'h00;
        @(posedge hclk);
        #1;
    endtask : pulse

    // Pops every modelled entry and compares it in order.
    task automatic drain;
        logic [8:0] e;
        while (q.size() > 0) begin
            e = q.pop_front();
            bus(1'b0, ADDR_RXDATA, 32'h0);
            cmp_word("rx entry", {23'h0, e}, rd);
        end
    endtask : drain

    // Prints the counts and the verdict, then ends the run.
    task automatic wrap_up;
        $display("COUNTS checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : wrap_up

    // Watchdog: the tests need well under a thousand cycles.
    initial begin
        repeat (20000) @(posedge hclk);
        miscompares++;
        wrap_up();
    end

    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        #1;
        cmp_flag("host_irq", 1'b0, host_irq);
        cmp_flag("hreadyout", 1'b1, hreadyout);
        cmp_flag("hresp", 1'b0, hresp);
        rd_chk("mask", ADDR_MASK, {24'h0, MASK_RESET});
        rd_chk("cause", ADDR_CAUSE, 32'h0);
        rd_chk("rxq", ADDR_RXQ, {30'h0, RXQ_EMPTY});
        bus(1'b1, 8'h1C, 32'hFFFF_FFFF);
        rd_chk("unmapped", 8'h1C, 32'h0);
        $display("TEST reset done");
        // Every event in both modes under a random mask.
        for (int m = 0; m < 2; m++) begin
            bus(1'b1, ADDR_CTRL, m);
            for (int b = 1; b < 8; b++) begin
                mask = $random(seed);
                exp_cause = mask & (8'h01 << b) & (m == 1 ? DATALINK_VALID : 8'hFF);
                bus(1'b1, ADDR_MASK, {24'h0, mask});
                pulse(b);
                repeat (3) @(posedge hclk);
                #1;
                cmp_flag("host_irq", exp_cause != 8'h00, host_irq);
                rd_chk("cause", ADDR_CAUSE, {24'h0, exp_cause});
                @(posedge hclk);
                #1;
                cmp_flag("host_irq cleared", 1'b0, host_irq);
            end
        end
        $display("TEST events done");
        // Queue codes with control block and data, handshake on.
        bus(1'b1, ADDR_CTRL, 32'h2);
        bus(1'b1, ADDR_MASK, 32'h1);
        u_remote.send(8'h3C, 1'b1, 1'b1);
        rd_chk("rxq", ADDR_RXQ, {30'h0, RXQ_CTRL});
        u_remote.send(8'hC3, 1'b0, 1'b1);
        rd_chk("rxq", ADDR_RXQ, {30'h0, RXQ_BOTH});
        cmp_flag("host_irq", 1'b1, host_irq);
        rd_chk("cause", ADDR_CAUSE, 32'h1);
        rd_chk("ctrl pop", ADDR_RXDATA, 32'h13C);
        rd_chk("rxq", ADDR_RXQ, {30'h0, RXQ_DATA});
        rd_chk("data pop", ADDR_RXDATA, 32'hC3);
        rd_chk("rxq", ADDR_RXQ, {30'h0, RXQ_EMPTY});
        bus(1'b1, ADDR_IRQ_STATUS, 32'h3);
        // Fill with handshake, then a polite sender waits out the hold-off.
        for (int i = 0; i < DEPTH; i++) begin
            q.push_back({1'b0, 8'($random(seed))});
            u_remote.send(q[i][7:0], 1'b0, 1'b1);
        end
        repeat (2) @(posedge hclk);
        #1;
        cmp_flag("hold_off", 1'b1, hold_off);
        q.push_back(9'h05A);
        fork
            u_remote.send(8'h5A, 1'b0, 1'b1);
        join_none
        repeat (6) @(posedge hclk);
        rd_chk("irq status", ADDR_IRQ_STATUS, 32'h0);
        drain();
        wait fork;
        rd_chk("rxq", ADDR_RXQ, {30'h0, RXQ_EMPTY});
        cmp_flag("hold_off", 1'b0, hold_off);
        bus(1'b1, ADDR_IRQ_STATUS, 32'h3);
        $display("TEST handshake done");
        // No handshake: the sender overruns the full queue.
        bus(1'b1, ADDR_CTRL, 32'h0);
        for (int i = 0; i < DEPTH + 2; i++) begin
            mask = $random(seed);
            if (i < DEPTH) begin
                q.push_back({1'b0, mask});
            end
            u_remote.send(mask, 1'b0, 1'b0);
        end
        cmp_flag("hold_off", 1'b0, hold_off);
        rd_chk("irq status", ADDR_IRQ_STATUS, 32'h1);
        bus(1'b1, ADDR_IRQ_MASK, 32'h1);
        repeat (2) @(posedge hclk);
        #1;
        cmp_flag("irq", 1'b1, irq);
        bus(1'b1, ADDR_IRQ_STATUS, 32'h1);
        repeat (2) @(posedge hclk);
        #1;
        cmp_flag("irq cleared", 1'b0, irq);
        drain();
        rd_chk("rxq", ADDR_RXQ, {30'h0, RXQ_EMPTY});
        rd_chk("irq drained", ADDR_IRQ_STATUS, 32'h2);
        $display("TEST overflow done");
        wrap_up();
    end
endmodule : testbench
